// ### rtl/core_fetch_consts.svh
// named offsets, field positions, reset values and vectors of the fetch/execute core
`ifndef CORE_FETCH_CONSTS_SVH
`define CORE_FETCH_CONSTS_SVH

// ==========================================================
// data space map
`define ADR_INDIRECT 7'h00
`define ADR_PCL 7'h02
`define ADR_STATUS 7'h03
`define ADR_FSR 7'h04
`define ADR_PC_HIGH_LATCH 7'h0a
`define SFR_LIMIT 7'h20
`define RAM0_BASE 8'h20
`define RAM0_TOP_DEF 8'h7f
`define RAM1_BASE 8'ha0
`define RAM1_TOP 8'hbf
`define RAM1_OFS 8'h40
`define COMMON_BASE 8'hf0
`define COMMON_OFS 8'ha0 // 80h bank step plus 20h RAM base, so f0..ff land on the cells of 70..7f

// ==========================================================
// core register fields and reset values
`define STATUS_BANK_BIT 5
`define STATUS_RST 8'h00
`define FSR_RST 8'h00
`define PC_HIGH_LATCH_RST 8'h00
`define CTRL_RST 8'h01
`define CTRL_RUN_BIT 0

// ==========================================================
// program counter and instruction word
`define RESET_VEC 13'h0000
`define IRQ_VEC 13'h0004
`define NOP_WORD 14'h0000
`define OPC_JUMP 3'h5
`define OPC_FILE 2'h0
`define DEST_BIT 7

// ==========================================================
// register indices beyond the data space (byte address = 4 * index)
`define REG_CTRL_IDX 9'h100
`define REG_TRACE_IDX 9'h101

`endif

// ### rtl/core_fetch_pkg.sv
// types shared by the fetch/execute core modules
package core_fetch_pkg;

    // ==========================================================
    // quarter-cycle phases, one-hot
    typedef enum logic [3:0] {
        PH1 = 4'b0001,
        PH2 = 4'b0010,
        PH3 = 4'b0100,
        PH4 = 4'b1000
    } phase_t;

    // ==========================================================
    // kind of location a data address resolves to
    typedef enum logic [2:0] {
        DK_NONE = 3'h0,
        DK_INDIRECT = 3'h1,
        DK_PCL = 3'h2,
        DK_STATUS = 3'h3,
        DK_FSR = 3'h4,
        DK_PC_HIGH_LATCH = 3'h5,
        DK_RAM = 3'h6
    } dkind_t;

endpackage : core_fetch_pkg

// ### rtl/dmap_if.sv
// address-decode carrier between the core and its data map decoder
`timescale 1ns/100ps
`default_nettype none

interface dmap_if;
    logic [7:0] addr;
    core_fetch_pkg::dkind_t kind;
    logic [6:0] ram_idx;

    modport requester (output addr, input kind, input ram_idx);
    modport decoder (input addr, output kind, output ram_idx);
endinterface : dmap_if

`default_nettype wire

// ### rtl/phase_gen.sv
// four-phase instruction cycle sequencer
`timescale 1ns/100ps
`default_nettype none

module phase_gen (
    input wire logic pclk, // system clock
    input wire logic presetn, // async reset, active low
    input wire logic run, // advance enable
    output core_fetch_pkg::phase_t phase // current phase, from flop
);
    core_fetch_pkg::phase_t phase_ff;
    core_fetch_pkg::phase_t nxt_phase;

    // ==========================================================
    // one-hot ring; resets to phase_4 so the first step is phase_1
    always_comb begin
        case (phase_ff)
            core_fetch_pkg::PH1: nxt_phase = core_fetch_pkg::PH2;
            core_fetch_pkg::PH2: nxt_phase = core_fetch_pkg::PH3;
            core_fetch_pkg::PH3: nxt_phase = core_fetch_pkg::PH4;
            core_fetch_pkg::PH4: nxt_phase = core_fetch_pkg::PH1;
            default: nxt_phase = core_fetch_pkg::PH1;
        endcase
    end

    // stalls in place while halted
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            phase_ff <= core_fetch_pkg::PH4;
        end else if (run) begin
            phase_ff <= nxt_phase; // RQ1
        end
    end

    assign phase = phase_ff;
endmodule : phase_gen

`default_nettype wire

// ### rtl/data_map.sv
// data address decoder: special area, banked RAM, common RAM alias
`timescale 1ns/100ps
`default_nettype none
`include "core_fetch_consts.svh"

module data_map #(
    parameter logic [7:0] BANK0_TOP = `RAM0_TOP_DEF, // last bank 0 RAM address
    parameter bit BANK1_RAM = 1'b0, // bank 1 RAM at a0..bf present
    parameter bit COMMON_RAM = 1'b1 // f0..ff alias 70..7f
) (
    dmap_if.decoder dm // address in, kind and RAM index out
);

    // ==========================================================
    // one decode shared by core and bus ports
    function automatic logic [9:0] decode(input logic [7:0] a);
        logic [6:0] lo;
        logic [7:0] ofs;
        core_fetch_pkg::dkind_t k;
        lo = a[6:0];
        ofs = 8'h00;
        k = core_fetch_pkg::DK_NONE;
        if (lo == `ADR_INDIRECT) begin
            k = core_fetch_pkg::DK_INDIRECT; // RQ18
        end else if (lo == `ADR_PCL) begin
            k = core_fetch_pkg::DK_PCL;
        end else if (lo == `ADR_STATUS) begin
            k = core_fetch_pkg::DK_STATUS;
        end else if (lo == `ADR_FSR) begin
            k = core_fetch_pkg::DK_FSR;
        end else if (lo == `ADR_PC_HIGH_LATCH) begin
            k = core_fetch_pkg::DK_PC_HIGH_LATCH;
        end else if (lo < `SFR_LIMIT) begin
            k = core_fetch_pkg::DK_NONE; // RQ12
        end else if (!a[7] && a <= BANK0_TOP) begin
            k = core_fetch_pkg::DK_RAM; // RQ13
            ofs = a - `RAM0_BASE;
        end else if (a[7] && COMMON_RAM && a >= `COMMON_BASE) begin
            k = core_fetch_pkg::DK_RAM; // RQ14
            ofs = a - `COMMON_OFS;
        end else if (a[7] && BANK1_RAM && a >= `RAM1_BASE && a <= `RAM1_TOP) begin
            k = core_fetch_pkg::DK_RAM; // RQ13
            ofs = a - `RAM1_OFS;
        end
        return {k, ofs[6:0]};
    endfunction : decode

    logic [9:0] res;
    assign res = decode(dm.addr);
    assign dm.kind = core_fetch_pkg::dkind_t'(res[9:7]);
    assign dm.ram_idx = res[6:0];
endmodule : data_map

`default_nettype wire

// ### rtl/core_fetch_pipeline.sv
// fetch/execute sequencer, program counter and data map of the small core
// Operation
// RQ1 - input clock divided by four into phases phase_1..phase_4 forming one cycle
// RQ2 - program counter increments once per cycle in phase_1, starting each fetch
// RQ3 - fetched program word latched into instruction register in phase_4
// RQ4 - fetch overlaps execute; one instruction completes per cycle
// RQ5 - latched instruction decoded and executed over phase_2 to phase_4
// RQ6 - operand read in phase_2, result written to data memory in phase_4
// RQ7 - counter-changing instructions take two cycles; prefetched word is discarded
// RQ8 - program counter is 13 bits wide, 8K words of 14 bits
// RQ9 - only 512, 1K or 2K words present; higher addresses wrap
// RQ10 - reset starts at address zero; interrupt entry loads address four
// RQ11 - direct addressing uses bank 1 when bank_select_bit is set, else bank 0
// RQ12 - first 32 addresses of each bank are special-function registers
// RQ13 - RAM at 20h-7Fh; largest variant also at A0h-BFh
// RQ14 - on revised variants F0h-FFh alias 70h-7Fh
// RQ15 - register file of 80, 96 or 128 bytes, direct and indirect access
// RQ16 - unimplemented data addresses read zero
// RQ17 - in RC mode, clock output at one quarter of the input clock
// RQ18 - indirect_access_location accesses the address held in indirect_pointer
`timescale 1ns/100ps
`default_nettype none
`include "core_fetch_consts.svh"

module core_fetch_pipeline #(
    parameter int PROG_WORDS = 512, // implemented program words, power of two
    parameter int RAM_BYTES = 128, // storage cells of the register file
    parameter logic [7:0] BANK0_TOP = `RAM0_TOP_DEF, // last bank 0 RAM address
    parameter bit BANK1_RAM = 1'b0, // bank 1 RAM at a0..bf present
    parameter bit COMMON_RAM = 1'b1 // f0..ff alias 70..7f
) (
    input wire logic pclk, // system clock
    input wire logic presetn, // async reset, active low
    input wire logic psel, // apb select
    input wire logic penable, // apb access phase
    input wire logic pwrite, // apb direction
    input wire logic [11:0] paddr, // apb byte address
    input wire logic [31:0] pwdata, // apb write data
    output logic [31:0] prdata, // apb read data
    output logic pready, // apb ready
    output logic pslverr, // apb error on unmapped index
    output logic [12:0] prog_addr, // program memory address
    input wire logic [13:0] prog_data, // program memory word
    input wire logic irq_req, // interrupt request level
    input wire logic rc_mode, // rc oscillator mode select
    input wire logic [7:0] alu_result, // result from execution unit
    output logic [7:0] operand, // operand read in phase_2
    output logic [13:0] instr, // instruction in execution
    output logic [3:0] phase, // one-hot phase
    output logic clk_out, // quarter-rate clock in rc mode
    output logic irq_taken // pulse on interrupt entry
);

    localparam logic [12:0] PROG_MASK = 13'(PROG_WORDS - 1);

    // ==========================================================
    // state
    logic [12:0] pc_ff;
    logic [12:0] prog_addr_ff;
    logic [13:0] ir_ff;
    logic flush_ff;
    logic [7:0] status_ff;
    logic [7:0] fsr_ff;
    logic [7:0] pc_high_latch_ff;
    logic [7:0] ctrl_ff;
    logic [7:0] operand_ff;
    logic [7:0] ram_ff [RAM_BYTES];
    logic clk_out_ff;
    logic irq_taken_ff;
    logic pready_ff;
    logic pslverr_ff;
    logic [31:0] prdata_ff;

    core_fetch_pkg::phase_t ph;
    logic run;
    logic ph1;
    logic ph2;
    logic ph4;

    // ==========================================================
    // phase sequencer
    assign run = ctrl_ff[`CTRL_RUN_BIT];

    phase_gen u_phase (
        .pclk(pclk),
        .presetn(presetn),
        .run(run),
        .phase(ph)
    );

    assign ph1 = run && (ph == core_fetch_pkg::PH1);
    assign ph2 = run && (ph == core_fetch_pkg::PH2);
    assign ph4 = run && (ph == core_fetch_pkg::PH4);

    // ==========================================================
    // instruction decode
    logic is_jump;
    logic is_file;
    logic dest_file;
    logic [12:0] jump_target;

    assign is_jump = (ir_ff[13:11] == `OPC_JUMP); // RQ5
    assign is_file = (ir_ff[13:12] == `OPC_FILE);
    assign dest_file = is_file && ir_ff[`DEST_BIT];
    assign jump_target = {pc_high_latch_ff[4:3], ir_ff[10:0]};

    // ==========================================================
    // address resolution; the indirect location redirects to the pointer
    dmap_if core_dm ();
    dmap_if bus_dm ();

    logic [7:0] direct_addr;
    logic [7:0] core_eff;
    logic [8:0] bus_idx;
    logic [7:0] bus_eff;
    logic bus_in_data;

    assign direct_addr = {status_ff[`STATUS_BANK_BIT], ir_ff[6:0]}; // RQ11
    assign core_eff = (ir_ff[6:0] == `ADR_INDIRECT) ? fsr_ff : direct_addr; // RQ18 RQ15
    assign bus_idx = paddr[10:2];
    assign bus_in_data = !paddr[11] && !bus_idx[8];
    assign bus_eff = (bus_idx[6:0] == `ADR_INDIRECT) ? fsr_ff : bus_idx[7:0]; // RQ18
    assign core_dm.addr = core_eff;
    assign bus_dm.addr = bus_eff;

    data_map #(
        .BANK0_TOP(BANK0_TOP),
        .BANK1_RAM(BANK1_RAM),
        .COMMON_RAM(COMMON_RAM)
    ) u_core_map (
        .dm(core_dm)
    );

    data_map #(
        .BANK0_TOP(BANK0_TOP),
        .BANK1_RAM(BANK1_RAM),
        .COMMON_RAM(COMMON_RAM)
    ) u_bus_map (
        .dm(bus_dm)
    );

    // read mux shared by the core and the bus
    function automatic logic [7:0] rd_val(input core_fetch_pkg::dkind_t k, input logic [6:0] i);
        logic [7:0] v;
        v = 8'h00; // RQ16
        if (k == core_fetch_pkg::DK_PCL) begin
            v = pc_ff[7:0];
        end else if (k == core_fetch_pkg::DK_STATUS) begin
            v = status_ff;
        end else if (k == core_fetch_pkg::DK_FSR) begin
            v = fsr_ff;
        end else if (k == core_fetch_pkg::DK_PC_HIGH_LATCH) begin
            v = pc_high_latch_ff;
        end else if (k == core_fetch_pkg::DK_RAM && 32'(i) < RAM_BYTES) begin
            v = ram_ff[i];
        end
        return v;
    endfunction : rd_val

    // ==========================================================
    // bus slave; ready is withheld around phase_4 so core and bus never write together
    logic bus_access;
    logic bus_commit;
    logic bus_wr;
    logic core_busy;

    assign bus_access = psel && penable;
    assign bus_commit = bus_access && pready_ff;
    assign bus_wr = bus_commit && pwrite && bus_in_data;
    assign core_busy = run && (ph == core_fetch_pkg::PH3 || ph == core_fetch_pkg::PH4);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff <= 32'h0000_0000;
        end else if (pready_ff) begin
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
        end else if (bus_access && !core_busy) begin
            pready_ff <= 1'b1;
            pslverr_ff <= 1'b0;
            prdata_ff <= 32'h0000_0000;
            if (bus_in_data) begin
                prdata_ff <= {24'h00_0000, rd_val(bus_dm.kind, bus_dm.ram_idx)};
            end else if (!paddr[11] && bus_idx == `REG_CTRL_IDX) begin
                prdata_ff <= {24'h00_0000, ctrl_ff};
            end else if (!paddr[11] && bus_idx == `REG_TRACE_IDX) begin
                prdata_ff <= {5'h00, ir_ff, pc_ff};
            end else begin
                pslverr_ff <= 1'b1;
            end
        end
    end

    // ==========================================================
    // data writes: core in phase_4, bus at its commit edge
    logic core_we;
    logic [7:0] wdata;
    core_fetch_pkg::dkind_t wkind;
    logic [6:0] widx;
    logic pcl_we;

    assign core_we = ph4 && dest_file; // RQ6
    assign wdata = core_we ? alu_result : pwdata[7:0];
    assign wkind = core_we ? core_dm.kind : (bus_wr ? bus_dm.kind : core_fetch_pkg::DK_NONE);
    assign widx = core_we ? core_dm.ram_idx : bus_dm.ram_idx;
    assign pcl_we = (core_we || bus_wr) && wkind == core_fetch_pkg::DK_PCL;

    // special registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status_ff <= `STATUS_RST;
            fsr_ff <= `FSR_RST;
            pc_high_latch_ff <= `PC_HIGH_LATCH_RST;
        end else if (core_we || bus_wr) begin
            if (wkind == core_fetch_pkg::DK_STATUS) begin
                status_ff <= wdata; // RQ11
            end else if (wkind == core_fetch_pkg::DK_FSR) begin
                fsr_ff <= wdata;
            end else if (wkind == core_fetch_pkg::DK_PC_HIGH_LATCH) begin
                pc_high_latch_ff <= wdata;
            end
        end
    end

    // register file storage; indirect to indirect and unmapped writes are dropped
    always_ff @(posedge pclk) begin
        if ((core_we || bus_wr) && wkind == core_fetch_pkg::DK_RAM && 32'(widx) < RAM_BYTES) begin
            ram_ff[widx] <= wdata; // RQ15
        end
    end

    // control register: run enable
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_ff <= `CTRL_RST;
        end else if (bus_commit && pwrite && !paddr[11] && bus_idx == `REG_CTRL_IDX) begin
            ctrl_ff <= pwdata[7:0];
        end
    end

    // ==========================================================
    // program counter: increment in phase_1, redirects in phase_4 or at a bus write to the counter
    logic redirect;
    logic irq_entry;

    assign irq_entry = ph4 && irq_req && !is_jump && !pcl_we;
    assign redirect = ph4 && (is_jump || pcl_we || irq_req);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pc_ff <= `RESET_VEC; // RQ10
        end else if (ph1) begin
            pc_ff <= pc_ff + 13'h0001; // RQ2 RQ8
        end else if (ph4 && is_jump) begin
            pc_ff <= jump_target; // RQ7
        end else if (pcl_we) begin
            pc_ff <= {pc_high_latch_ff[4:0], wdata}; // RQ7
        end else if (irq_entry) begin
            pc_ff <= `IRQ_VEC; // RQ10
        end
    end

    // fetch address presented in phase_1, folded into the implemented space
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prog_addr_ff <= `RESET_VEC;
        end else if (ph1) begin
            prog_addr_ff <= pc_ff & PROG_MASK; // RQ9
        end
    end

    // a bus write to the counter outside phase_4 still spoils the word in flight
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flush_ff <= 1'b0;
        end else if (ph4) begin
            flush_ff <= 1'b0;
        end else if (pcl_we) begin
            flush_ff <= 1'b1;
        end
    end

    // ==========================================================
    // instruction register: next word latched while current executes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ir_ff <= `NOP_WORD;
        end else if (ph4) begin
            if (redirect || flush_ff) begin
                ir_ff <= `NOP_WORD; // RQ7
            end else begin
                ir_ff <= prog_data; // RQ3 RQ4
            end
        end
    end

    // operand fetch
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            operand_ff <= 8'h00;
        end else if (ph2) begin
            operand_ff <= rd_val(core_dm.kind, core_dm.ram_idx); // RQ6 RQ16
        end
    end

    // ==========================================================
    // quarter-rate clock, high in phase_1 and phase_2; idle low outside rc mode
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clk_out_ff <= 1'b0;
        end else if (run) begin
            clk_out_ff <= rc_mode && (ph == core_fetch_pkg::PH4 || ph == core_fetch_pkg::PH1); // RQ17
        end
    end

    // interrupt entry marker
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_taken_ff <= 1'b0;
        end else begin
            irq_taken_ff <= irq_entry;
        end
    end

    // ==========================================================
    // outputs
    assign prdata = prdata_ff;
    assign pready = pready_ff;
    assign pslverr = pslverr_ff;
    assign prog_addr = prog_addr_ff;
    assign operand = operand_ff;
    assign instr = ir_ff;
    assign phase = ph;
    assign clk_out = clk_out_ff;
    assign irq_taken = irq_taken_ff;
endmodule : core_fetch_pipeline

`default_nettype wire

// ### dv/core_fetch_monitor.sv
// assertion checker on the ports of the fetch/execute core
`timescale 1ns/100ps
`default_nettype none

module core_fetch_monitor #(
    parameter int PROG_WORDS = 512 // implemented program words
) (
    input wire logic pclk, // clock
    input wire logic presetn, // async reset, active low
    input wire logic psel, // apb select
    input wire logic penable, // apb access phase
    input wire logic [31:0] prdata, // apb read data
    input wire logic pready, // apb ready
    input wire logic pslverr, // apb error
    input wire logic [12:0] prog_addr, // fetch address
    input wire logic rc_mode, // rc mode select
    input wire logic [7:0] operand, // operand latch
    input wire logic [13:0] instr, // executing word
    input wire logic [3:0] phase, // one-hot phase
    input wire logic clk_out, // quarter-rate clock
    input wire logic irq_taken // interrupt entry pulse
);
    // ==========================================================
    // helper logic
    logic [3:0] ph_rot;
    logic [12:0] jmp_tgt_ff;

    assign ph_rot = {phase[2:0], phase[3]};

    // jump target of the executing word, masked because the fetch path wraps
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            jmp_tgt_ff <= 13'h0000;
        end else if (phase == 4'b1000) begin
            jmp_tgt_ff <= {2'b00, instr[10:0]} & 13'(PROG_WORDS - 1);
        end
    end

    // ==========================================================
    // properties
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    AST_PH_ROT: assert property (phase != 4'b0000 |=>
        $onehot(phase) && (phase == $past(phase) || phase == $past(ph_rot))) else $error("phase out of order");
    AST_FETCH_PH1: assert property ($changed(prog_addr) |-> $past(phase) == 4'b0001)
        else $error("fetch address moved outside phase_1");
    AST_IR_PH4: assert property ($changed(instr) |-> $past(phase) == 4'b1000)
        else $error("instruction latched outside phase_4");
    AST_OPND_PH2: assert property ($changed(operand) |-> $past(phase) == 4'b0010)
        else $error("operand read outside phase_2");
    AST_WRAP: assert property (prog_addr < 13'(PROG_WORDS)) else $error("fetch address beyond program size");
    AST_JUMP: assert property (phase == 4'b1000 && instr[13:11] == 3'b101 |-> ##2 prog_addr == jmp_tgt_ff)
        else $error("jump target not fetched");
    AST_VEC: assert property (irq_taken |-> ##[0:4] prog_addr == 13'h0004) else $error("no fetch at vector");
    AST_RDY: assert property (pready |-> psel && penable ##1 !pready) else $error("ready not a single pulse");
    AST_ERR_ZERO: assert property (pslverr |-> pready && prdata == 32'h0) else $error("refused read not zero");
    AST_CLKQ: assert property ($past(rc_mode) == rc_mode |->
        clk_out == (rc_mode && (phase[0] || phase[1]))) else $error("clock output wrong");
endmodule : core_fetch_monitor

bind core_fetch_pipeline core_fetch_monitor #(.PROG_WORDS(PROG_WORDS)) core_fetch_monitor_i (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .prog_addr(prog_addr), .rc_mode(rc_mode), .operand(operand), .instr(instr), .phase(phase),
    .clk_out(clk_out), .irq_taken(irq_taken));

`default_nettype wire

// ### dv/prog_mem_model.sv
// program memory array model answering the fetch address
`timescale 1ns/100ps
`default_nettype none

module prog_mem_model (
    input wire logic pclk, // clock
    input wire logic [12:0] prog_addr, // fetch address
    output logic [13:0] prog_data // word read
);
    logic [13:0] mem [8192];
    logic [12:0] held_ff;

    // word settles a cycle after the address; meanwhile it shows a wrong pattern
    always_ff @(posedge pclk) begin
        held_ff <= prog_addr;
    end
    assign prog_data = (held_ff == prog_addr) ? mem[prog_addr] : ~mem[held_ff];

    // blank array reads as no-operation words
    initial begin
        foreach (mem[k]) mem[k] = 14'h0000;
    end
endmodule : prog_mem_model

`default_nettype wire

// ### dv/tb_core_fetch_pipeline.sv
// self-checking bench for the fetch/execute core
`timescale 1ns/100ps
`default_nettype none

module tb_core_fetch_pipeline;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic irq_req = 1'b0, rc_mode = 1'b0, pready, pslverr, clk_out, irq_taken, err;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [12:0] prog_addr;
    logic [13:0] prog_data, instr;
    logic [7:0] alu_result = 8'h00, operand, v, d;
    logic [3:0] phase;
    int fail_count = 0, samples_checked = 0, seed = 32'h0213a120;

    always #10 pclk = ~pclk;

    core_fetch_pipeline core_fetch_pipeline_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .prog_addr(prog_addr), .prog_data(prog_data), .irq_req(irq_req), .rc_mode(rc_mode),
        .alu_result(alu_result), .operand(operand), .instr(instr), .phase(phase), .clk_out(clk_out),
        .irq_taken(irq_taken));
    prog_mem_model prog_mem_model_i (.pclk(pclk), .prog_addr(prog_addr), .prog_data(prog_data));

    // ==========================================================
    // reporting
    task automatic results;
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : results

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string m);
        samples_checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("MISMATCH %0t %s seen %h expected %h", $time, m, seen, exp);
        end
    endtask : check

    // ==========================================================
    // bus and wait helpers; entered just after a rising edge
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] dat);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= dat;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            fail_count++;
            results();
        end
        @(posedge pclk);
    endtask : apb

    task automatic wr_rd(input logic [11:0] wa, input logic [7:0] x, input logic [11:0] ra, input logic [7:0] e);
        apb(1'b1, wa, {24'h0, x});
        apb(1'b0, ra, 32'h0);
        check(rd, {24'h0, e}, "register read back");
    endtask : wr_rd

    // expected read-back of a data byte written with x: bank 0 RAM and common RAM only in this variant
    function automatic logic [7:0] exp_rd(input logic [11:0] a, input logic [7:0] x);
        return ((a[9:2] >= 8'h20 && a[9:2] <= 8'h7f && !a[11:10]) || a[9:2] >= 8'hf0) ? x : 8'h00;
    endfunction : exp_rd

    // bounded wait for a fetch address; running out counts as a mismatch
    task automatic wait_pa(input logic [12:0] a, input int lim);
        int n;
        for (n = 0; prog_addr !== a && n < lim; n++) @(posedge pclk);
        check(prog_addr, a, "fetch address");
        if (prog_addr !== a) results();
    endtask : wait_pa

    // operand of the next read of file 0x30, after the current one has gone
    task automatic chk_op(input logic [7:0] e);
        int n;
        for (n = 0; instr === 14'h0030 && n < 8; n++) @(posedge pclk);
        for (n = 0; instr !== 14'h0030 && n < 3000; n++) @(posedge pclk);
        if (instr !== 14'h0030) begin
            fail_count++;
            results();
        end
        // latched at the edge ending phase_2, seen settled one edge later; keeps the bus aligned
        repeat (2) @(posedge pclk);
        check(operand, e, "operand");
    endtask : chk_op

    // ==========================================================
    // main sequence: jump at 5 to a write/read pair at 0x100
    initial begin
        #1;
        prog_mem_model_i.mem[5] = 14'h2900;
        prog_mem_model_i.mem[13'h100] = 14'h00b0;
        prog_mem_model_i.mem[13'h101] = 14'h0030;
        repeat (5) @(posedge pclk);
        v = 8'($random(seed));
        alu_result <= v;
        presetn <= 1'b1;
        @(posedge pclk);
        #1;
        check(phase, 4'b0001, "first phase");
        check(prog_addr, 13'h0000, "reset address");
        wait_pa(13'h100, 100);
        wait_pa(13'h101, 8);
        chk_op(v);
        apb(1'b1, 12'h00c, 32'h20);
        chk_op(8'h00);
        apb(1'b0, 12'h00c, 32'h0);
        check(rd[5], 1'b1, "bank bit");
        apb(1'b1, 12'h00c, 32'h0);
        repeat (6) begin
            d = 8'($random(seed));
            paddr <= 12'h100 + 12'(4 * ($random(seed) & 32'h1f));
            @(posedge pclk);
            wr_rd(paddr, d, paddr, exp_rd(paddr, d));
            wr_rd(12'h010, paddr[9:2], 12'h000, d);
            wr_rd(12'h200, ~d, paddr, ~d);
        end
        wr_rd(12'h3d4, d, 12'h1d4, exp_rd(12'h1d4, d));
        wr_rd(12'h294, d, 12'h294, exp_rd(12'h294, d));
        wr_rd(12'h01c, d, 12'h01c, exp_rd(12'h01c, d));
        apb(1'b0, 12'h800, 32'h0);
        check(err, 1'b1, "unmapped refused");
        apb(1'b0, 12'h400, 32'h0);
        check(rd, 32'h1, "run bit reset");
        apb(1'b1, 12'h008, 32'h40);
        wait_pa(13'h040, 12);
        irq_req <= 1'b1;
        for (int n = 0; irq_taken !== 1'b1 && n < 20; n++) @(posedge pclk);
        irq_req <= 1'b0;
        wait_pa(13'h004, 8);
        rc_mode <= 1'b1;
        wait_pa(13'h1ff, 3000);
        wait_pa(13'h000, 5);
        check(clk_out, 1'b1, "clock output in phase_2");
        repeat (2) @(posedge pclk);
        check(clk_out, 1'b0, "clock output in phase_4");
        results();
    end
endmodule : tb_core_fetch_pipeline

`default_nettype wire
